// File: icc_consts.svh
// Purpose: offsets, field positions, reset values and mode codes of the input capture channels
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   definitions only; included by every design file that needs a number
//
// How it works
// - each qualifying pin event latches the selected 16-bit time base count
// - simple modes capture every falling, every rising, or every edge
// - prescaled modes capture every fourth or every sixteenth rising edge
// - captured counts wait in a four-entry store, read out oldest first
// - mode 001 captures both edges; captures-per-interrupt is ignored there
// - mode 111 makes the pin a rising-edge interrupt only in Sleep or Idle
// - captures-per-interrupt 00..11 interrupts after every 1st..4th capture
// - read-only overflow flag sits at bit 4, software cannot write it
// - read-only not-empty flag at bit 3 shows unread captured values
// - timer select at bit 7 picks which shared time base is latched
// - stop-in-idle at bit 13 halts capture while the CPU idles, but not the mode 111 pin interrupt
// - a pin event can wake the device from Sleep or Idle
// - only the first two channels may raise DMA transfer requests
// - up to eight independent channels, each with control, pin and store
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH

// ---------------------------------------------------------------------------
// register map: channel n at base n * stride
// ---------------------------------------------------------------------------
`define ICC_CHAN_STRIDE   8
`define ICC_OFS_CTRL      1'b0
`define ICC_OFS_BUF       1'b1
`define ICC_CTRL_RESET    16'h0000
`define ICC_CTRL_WMASK    16'h20e7

// ---------------------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------------------
`define ICC_BIT_STOP_IDLE 13
`define ICC_BIT_TMR_SEL   7
`define ICC_BIT_PER_IRQ   5
`define ICC_BIT_OVF       4
`define ICC_BIT_NEMPTY    3
`define ICC_BIT_MODE      0

// ---------------------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------------------
`define ICC_MODE_OFF      3'h0
`define ICC_MODE_BOTH     3'h1
`define ICC_MODE_FALL     3'h2
`define ICC_MODE_RISE     3'h3
`define ICC_MODE_RISE4    3'h4
`define ICC_MODE_RISE16   3'h5
`define ICC_MODE_UNUSED   3'h6
`define ICC_MODE_WAKE     3'h7
`define ICC_PRESC4_LAST   4'h3
`define ICC_PRESC16_LAST  4'hf

`endif

// File: icc_pkg.sv
// Purpose: shared types and helpers of the input capture channels
// Assumes: icc_consts.svh supplies the numbers
// Notes:   no state, definitions only
`include "icc_consts.svh"

package icc_pkg;

  typedef logic [15:0] icc_word_t;
  typedef logic [2:0]  icc_mode_t;

  // channel is live for a mode that captures into the store
  function automatic logic icc_mode_captures(input icc_mode_t m);
    return (m != `ICC_MODE_OFF) && (m != `ICC_MODE_UNUSED) && (m != `ICC_MODE_WAKE);
  endfunction

endpackage

// File: icc_fifo_if.sv
// Purpose: carrier between a channel's control logic and its capture store
// Assumes: one clock domain
// Notes:   ctl side pushes and pops, store side answers with head and flags
`timescale 1ns/10ps

interface icc_fifo_if #(parameter int W = 16);
  logic         push;
  logic [W-1:0] push_data;
  logic         pop;
  logic         clr;
  logic [W-1:0] rd_data;
  logic         not_empty;
  logic         ovf;

  modport ctl   (output push, push_data, pop, clr, input rd_data, not_empty, ovf);
  modport store (input push, push_data, pop, clr, output rd_data, not_empty, ovf);
endinterface

// File: icc_fifo.sv
// Purpose: capture store with overflow flag
// Assumes: pop is only issued while not empty
// Notes:   a push into a full store is dropped; overflow sticks until clr
`timescale 1ns/10ps

module icc_fifo #(
  parameter int DEPTH = 4,
  parameter int W     = 16
) (
  input  wire logic clk,
  input  wire logic rst_b,
  icc_fifo_if.store f
);
  import icc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("icc_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          ovf;

  wire full    = (count == (AW+1)'(DEPTH));
  wire do_push = f.push && !full;
  wire do_pop  = f.pop && (count != '0);

  // storage keeps no reset; only pointers define validity
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= f.push_data;
  end

  // pointers and occupancy, oldest entry leaves first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      ovf    <= 1'b0;
    end
    else if (f.clr)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      ovf    <= 1'b0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(do_push);
      rd_ptr <= rd_ptr + AW'(do_pop);
      count  <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (f.push && full)
        ovf <= 1'b1;
    end
  end

  assign f.rd_data   = mem[rd_ptr];
  assign f.not_empty = (count != '0);
  assign f.ovf       = ovf;
endmodule

// File: icc_edge.sv
// Purpose: pin synchroniser, edge detector and rising-edge prescaler
// Assumes: pin is asynchronous to clk
// Notes:   capture strobe lags the pin by two clock edges
`timescale 1ns/10ps
`include "icc_consts.svh"

module icc_edge (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             pin,
  input  wire icc_pkg::icc_mode_t mode,
  input  wire logic             run,
  output logic                  cap_evt,
  output logic                  rise_evt
);
  import icc_pkg::*;

  logic       sync1;
  logic       sync2;
  logic       prev;
  logic [3:0] presc;

  // two flops before any logic looks at the pin; prev only reads sync2
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  wire rise = sync2 && !prev;
  wire fall = !sync2 && prev;
  wire [3:0] presc_last = (mode == `ICC_MODE_RISE16) ? `ICC_PRESC16_LAST : `ICC_PRESC4_LAST;
  wire presc_mode = (mode == `ICC_MODE_RISE4) || (mode == `ICC_MODE_RISE16);
  wire presc_hit  = rise && (presc == presc_last);

  // prescaler restarts whenever the channel is not counting rising edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      presc <= 4'h0;
    else if (!presc_mode || !run)
      presc <= 4'h0;
    else if (rise)
      presc <= presc_hit ? 4'h0 : presc + 4'h1;
  end

  // edge qualification per mode
  always_comb
  begin
    cap_evt = 1'b0;
    if (run)
    begin
      unique case (mode)
        `ICC_MODE_BOTH   : cap_evt = rise || fall;
        `ICC_MODE_FALL   : cap_evt = fall;
        `ICC_MODE_RISE   : cap_evt = rise;
        `ICC_MODE_RISE4,
        `ICC_MODE_RISE16 : cap_evt = presc_hit;
        default          : cap_evt = 1'b0;
      endcase
    end
  end

  assign rise_evt = rise;
endmodule

// File: icc_top.sv
// Purpose: bank of input capture channels behind an APB slave
// Assumes: time bases and CPU power states come from logic on CLK
// Notes:   zero-wait APB; a read of a buffer word pops its store
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "icc_consts.svh"

module icc_top #(
  parameter int NUM_CHAN = 8,
  parameter int DEPTH    = 4,
  parameter int AW       = 12
) (
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [AW-1:0]       PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic [NUM_CHAN-1:0] CAPTURE_PIN,
  input  wire icc_pkg::icc_word_t  TIME_BASE_FIRST,
  input  wire icc_pkg::icc_word_t  TIME_BASE_SECOND,
  input  wire logic                CPU_IDLE,
  input  wire logic                CPU_SLEEP,
  output logic [NUM_CHAN-1:0]      CAPTURE_IRQ,
  output logic [1:0]               DMA_REQ,
  output logic                     WAKE_REQ
);
  import icc_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  initial
  begin
    if (NUM_CHAN < 2 || NUM_CHAN > 8)
      $error("icc_top: NUM_CHAN must lie between 2 and 8");
    if (DEPTH != 4)
      $error("icc_top: captures-per-interrupt field serves a store of 4");
    if (AW < 7)
      $error("icc_top: AW too small for the channel map");
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  // channel index from stride 8 bytes; word select picks control or buffer
  wire [3:0] sel_chan  = PADDR[6:3];
  wire       sel_word  = PADDR[2];
  wire       hi_zero   = (PADDR[AW-1:7] == '0);
  wire       addr_ok   = hi_zero && (PADDR[1:0] == 2'b00) && (sel_chan < 4'(NUM_CHAN));
  wire       setup     = PSEL && !PENABLE;
  wire       access    = PSEL && PENABLE;
  wire       wr_access = access && PWRITE && addr_ok;
  wire       rd_access = access && !PWRITE && addr_ok;

  // zero-wait slave: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !addr_ok;

  // ---------------------------------------------------------------------------
  // per-channel state seen by the read mux and the system outputs
  // ---------------------------------------------------------------------------
  icc_word_t ctrl_rd  [NUM_CHAN];
  icc_word_t head     [NUM_CHAN];
  logic [NUM_CHAN-1:0] wake_hit;
  logic [NUM_CHAN-1:0] irq;

  // power-state shorthands
  wire lowpow = CPU_IDLE || CPU_SLEEP;

  // ---------------------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    icc_fifo_if #(.W(16)) fif ();

    logic [15:0] ctrl;
    logic [1:0]  irq_cnt;
    logic        irq_q;
    logic        cap_evt;
    logic        rise_evt;

    // named views of the control fields
    wire icc_mode_t mode      = ctrl[`ICC_BIT_MODE +: 3];
    wire [1:0]      per_irq   = ctrl[`ICC_BIT_PER_IRQ +: 2];
    wire            tmr_sel   = ctrl[`ICC_BIT_TMR_SEL];
    wire            stop_idle = ctrl[`ICC_BIT_STOP_IDLE];

    // halted while idling with stop-in-idle set; off modes never capture
    wire halted = CPU_IDLE && stop_idle;
    wire run    = icc_mode_captures(mode) && !halted;
    wire hit_me = (sel_chan == 4'(c));
    wire ctl_wr = wr_access && hit_me && (sel_word == `ICC_OFS_CTRL);
    wire buf_rd = rd_access && hit_me && (sel_word == `ICC_OFS_BUF);

    icc_edge u_edge (
      .clk      (CLK),
      .rst_b    (RST_B),
      .pin      (CAPTURE_PIN[c]),
      .mode     (mode),
      .run      (run),
      .cap_evt  (cap_evt),
      .rise_evt (rise_evt)
    );

    icc_fifo #(.DEPTH(DEPTH), .W(16)) u_fifo (
      .clk   (CLK),
      .rst_b (RST_B),
      .f     (fif.store)
    );

    // selected time base goes straight into the store on the capture strobe
    assign fif.push      = cap_evt;
    assign fif.push_data = tmr_sel ? TIME_BASE_FIRST : TIME_BASE_SECOND;
    assign fif.pop       = buf_rd && fif.not_empty;
    // leaving a capturing mode empties the store and clears overflow
    assign fif.clr       = !icc_mode_captures(mode);

    // control register: only the writable bits store a value
    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        ctrl <= `ICC_CTRL_RESET;
      else if (ctl_wr)
        ctrl <= PWDATA[15:0] & `ICC_CTRL_WMASK;
    end

    // status bits are live, never stored from the bus
    always_comb
    begin
      ctrl_rd[c]                     = ctrl;
      ctrl_rd[c][`ICC_BIT_OVF]       = fif.ovf;
      ctrl_rd[c][`ICC_BIT_NEMPTY]    = fif.not_empty;
    end
    assign head[c] = fif.rd_data;

    // interrupt pacing: every-edge mode ignores the per-interrupt field
    wire [1:0] irq_last = (mode == `ICC_MODE_BOTH) ? 2'b00 : per_irq;
    wire       cnt_done = cap_evt && (irq_cnt == irq_last);
    // mode 111: rising edge raises the interrupt only in a low-power state
    wire       wake_evt = (mode == `ICC_MODE_WAKE) && lowpow && rise_evt;

    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        irq_cnt <= 2'b00;
      else if (!run || cnt_done)
        irq_cnt <= 2'b00;
      else if (cap_evt)
        irq_cnt <= irq_cnt + 2'b01;
    end

    // interrupt strobe is registered so it never glitches out of the block
    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        irq_q <= 1'b0;
      else
        irq_q <= cnt_done || wake_evt;
    end

    assign irq[c]      = irq_q;
    // a qualifying event while asleep or idle may wake the device
    assign wake_hit[c] = lowpow && (cap_evt || wake_evt);
  end

  // ---------------------------------------------------------------------------
  // outputs to the system
  // ---------------------------------------------------------------------------
  logic wake_q;

  // wake is registered: the CPU power controller samples a clean level
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      wake_q <= 1'b0;
    else
      wake_q <= |wake_hit;
  end

  assign CAPTURE_IRQ = irq;
  // only channels 0 and 1 may request DMA; depth 1 is software's job
  assign DMA_REQ     = irq[1:0];
  assign WAKE_REQ    = wake_q;

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  // read data is latched in the setup cycle, so the pop at the access edge
  // cannot disturb the word the master is sampling
  icc_word_t rd_word;
  wire [2:0] rd_idx = sel_chan[2:0];

  always_comb
  begin
    rd_word = 16'h0000;
    if (addr_ok)
      rd_word = (sel_word == `ICC_OFS_BUF) ? head[rd_idx] : ctrl_rd[rd_idx];
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      PRDATA <= 32'h0000_0000;
    else if (setup && !PWRITE)
      PRDATA <= {16'h0000, rd_word};
  end
endmodule

// File: icc_top_monitor.sv
// Purpose: port checks of the capture bank
// Assumes: pin edges are spaced well beyond the sync chain
// Notes:   bound at the foot of this file
`timescale 1ns/10ps

module icc_top_monitor #(
  parameter int AW = 12
) (
  input wire logic          CLK,
  input wire logic          RST_B,
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic          PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0]   PRDATA,
  input wire logic          PSLVERR,
  input wire logic [7:0]    CAPTURE_PIN,
  input wire logic          CPU_IDLE,
  input wire logic          CPU_SLEEP,
  input wire logic [7:0]    CAPTURE_IRQ,
  input wire logic [1:0]    DMA_REQ,
  input wire logic          WAKE_REQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // -------------------------------------------
  // properties
  // -------------------------------------------
  property p_dma;
    DMA_REQ == CAPTURE_IRQ[1:0];
  endproperty
  a_dma: assert property (p_dma) else $error("dma differs from irq");
  property p_err;
    PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR;
  endproperty
  a_err: assert property (p_err) else $error("no error on odd address");
  property p_err_phase;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray error");
  property p_rd_hi;
    PSEL && PENABLE && !PWRITE |-> PRDATA[31:16] == 16'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_rd_unmap;
    PSEL && !PENABLE && !PWRITE && PADDR[AW-1:7] != '0 |=> PRDATA == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped data");
  property p_rd_hold;
    !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_wake_lp;
    WAKE_REQ |-> $past(CPU_IDLE || CPU_SLEEP);
  endproperty
  a_wake_lp: assert property (p_wake_lp) else $error("wake while running");
  property p_irq_pin;
    CAPTURE_IRQ[0] |-> $past(CAPTURE_PIN[0], 3) != $past(CAPTURE_PIN[0], 4);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq without edge");
  property p_wake_pin;
    WAKE_REQ |-> $past(CAPTURE_PIN, 3) != $past(CAPTURE_PIN, 4);
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake without edge");
endmodule

bind icc_top icc_top_monitor #(.AW(AW)) u_mon (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CAPTURE_PIN(CAPTURE_PIN),
  .CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP), .CAPTURE_IRQ(CAPTURE_IRQ),
  .DMA_REQ(DMA_REQ), .WAKE_REQ(WAKE_REQ));

// File: icc_pin_src.sv
// Purpose: external signal on a capture pin
// Assumes: one toggle per request
// Notes:   busy covers the pin sync chain
`timescale 1ns/10ps

module icc_pin_src (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic go,
  output logic      pin,
  output logic      busy
);
  logic [2:0] cnt;

  // quiet spell after each edge keeps edges far apart for the sync chain
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin <= 1'b0;
      cnt <= 3'h0;
    end
    else if (go)
    begin
      pin <= ~pin;
      cnt <= 3'h7;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign busy = cnt != 3'h0;
endmodule

// File: input_capture_channel_tb_top.sv
// Purpose: self-checking bench of the capture bank
// Assumes: channels 0 to 2 share one pin source
// Notes:   time bases held steady around each edge
`timescale 1ns/10ps
`include "icc_consts.svh"

module input_capture_channel_tb_top;
  import icc_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, go, idle, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pin, busy, wake;
  logic [7:0]  irq;
  logic [1:0]  dma;
  icc_word_t   tb1, tb2;
  int          errors, comparisons, irq_n, dma_n, wake_n, irq1_n, dma1_n, irq2_n;

  icc_top dut (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CAPTURE_PIN({5'h0, pin, pin, pin}), .TIME_BASE_FIRST(tb1),
    .TIME_BASE_SECOND(tb2), .CPU_IDLE(idle), .CPU_SLEEP(sleep),
    .CAPTURE_IRQ(irq), .DMA_REQ(dma), .WAKE_REQ(wake));
  icc_pin_src u_src (.clk(clk), .rst_b(rst_b), .go(go), .pin(pin), .busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulse counters, read as differences by the scenarios
  always @(posedge clk)
  begin
    irq_n  <= irq_n + int'(irq[0] === 1'b1);
    dma_n  <= dma_n + int'(dma[0] === 1'b1);
    wake_n <= wake_n + int'(wake === 1'b1);
    irq1_n <= irq1_n + int'(irq[1] === 1'b1);
    dma1_n <= dma1_n + int'(dma[1] === 1'b1);
    irq2_n <= irq2_n + int'(irq[2] === 1'b1);
  end

  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {16'h0, d}, q, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] x, input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, {q, 31'h0, e}, {16'h0, x, 32'h0});
  endtask

  // one pin edge with time bases marked by the edge index
  task automatic tog(input int k);
    int n;
    n = 0;
    tb1 <= 16'ha0 + 16'(k);
    tb2 <= 16'hb0 + 16'(k);
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
  endtask

  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rdc(12'h000, 16'h0000, "ctrl reset");
    wr(12'h008, 16'hffff);
    rdc(12'h008, 16'h20e7, "ctrl mask");
    apb(1'b0, 12'h080, 32'h0, q, e);
    chk("unmapped high", {q, 31'h0, e}, 64'h1);
    wr(12'h008, 16'h0000);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk("unmapped", {q, 31'h0, e}, 64'h1);
    apb(1'b0, 12'h002, 32'h0, q, e);
    chk("misaligned err", e, 1'b1);
  endtask

  task automatic t_modes();
    logic [2:0] md[7] = '{`ICC_MODE_OFF, `ICC_MODE_RISE4, `ICC_MODE_UNUSED,
      `ICC_MODE_BOTH, `ICC_MODE_FALL, `ICC_MODE_RISE, `ICC_MODE_RISE16};
    int         nn[7] = '{2, 32, 2, 4, 8, 8, 32};
    logic [1:0] ic[7] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h2, 2'h3};
    icc_word_t  exq[$];
    logic       ts, q;
    int         pc, i0, d0;
    for (int m = 0; m < 7; m++)
    begin
      ts = m[0];
      wr(12'h000, {8'h0, ts, ic[m], 2'h0, md[m]});
      exq = {};
      pc = 0;
      i0 = irq_n;
      d0 = dma_n;
      for (int k = 0; k < nn[m]; k++)
      begin
        tog(k);
        pc += int'(k % 2 == 0);
        case (md[m])
          `ICC_MODE_BOTH:   q = 1'b1;
          `ICC_MODE_FALL:   q = k % 2 == 1;
          `ICC_MODE_RISE:   q = k % 2 == 0;
          `ICC_MODE_RISE4:  q = k % 2 == 0 && pc % 4 == 0;
          `ICC_MODE_RISE16: q = k % 2 == 0 && pc % 16 == 0;
          default:          q = 1'b0;
        endcase
        if (q)
          exq.push_back(ts ? 16'ha0 + 16'(k) : 16'hb0 + 16'(k));
      end
      pc = md[m] == `ICC_MODE_BOTH ? exq.size() : exq.size() / (int'(ic[m]) + 1);
      chk("irq count", irq_n - i0, pc);
      chk("dma count", dma_n - d0, pc);
      rdc(12'h000, {8'h0, ts, ic[m], 1'b0, exq.size() != 0, md[m]}, "ctrl");
      foreach (exq[j])
        rdc(12'h004, exq[j], "capture");
      rdc(12'h000, {8'h0, ts, ic[m], 2'h0, md[m]}, "ctrl drained");
    end
  endtask

  task automatic t_ovf();
    wr(12'h000, 16'h0013);
    rdc(12'h000, 16'h0003, "ovf write");
    for (int k = 0; k < 10; k++)
      tog(k);
    rdc(12'h000, 16'h001b, "ovf set");
    wr(12'h000, 16'h0003);
    rdc(12'h000, 16'h001b, "ovf held");
    for (int k = 0; k < 8; k += 2)
      rdc(12'h004, 16'hb0 + 16'(k), "ovf data");
    rdc(12'h000, 16'h0013, "ovf empty");
    wr(12'h000, 16'h0000);
    rdc(12'h000, 16'h0000, "ovf off");
  endtask

  task automatic t_idle();
    int w0, i0;
    idle <= 1'b1;
    wr(12'h000, 16'h2003);
    w0 = wake_n;
    tog(0);
    tog(1);
    rdc(12'h000, 16'h2003, "halted");
    wr(12'h000, 16'h0003);
    tog(2);
    tog(3);
    rdc(12'h004, 16'hb2, "idle capture");
    chk("idle wake", wake_n - w0, 1);
    wr(12'h000, 16'h0007);
    idle <= 1'b0;
    i0 = irq_n;
    tog(4);
    tog(5);
    chk("pin irq run", irq_n - i0, 0);
    sleep <= 1'b1;
    w0 = wake_n;
    tog(6);
    tog(7);
    chk("pin irq sleep", irq_n - i0, 1);
    chk("sleep wake", wake_n - w0, 1);
    rdc(12'h000, 16'h0007, "pin only");
    sleep <= 1'b0;
    wr(12'h000, 16'h0000);
  endtask

  task automatic t_chan();
    int i1, d1, i2;
    wr(12'h008, 16'h0083);
    wr(12'h010, 16'h0003);
    i1 = irq1_n;
    d1 = dma1_n;
    i2 = irq2_n;
    tog(0);
    tog(1);
    chk("ch1 irq", irq1_n - i1, 1);
    chk("ch1 dma", dma1_n - d1, 1);
    chk("ch2 irq", irq2_n - i2, 1);
    rdc(12'h00c, 16'h00a0, "ch1 capture");
    rdc(12'h014, 16'h00b0, "ch2 capture");
    wr(12'h008, 16'h0000);
    wr(12'h010, 16'h0000);
  endtask

  task automatic end_sim();
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    {rst_b, psel, penable, pwrite, go, idle, sleep} = 7'h0;
    {paddr, pwdata, tb1, tb2} = '0;
    {errors, comparisons, irq_n, dma_n, wake_n, irq1_n, dma1_n, irq2_n} = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_ovf();
    t_idle();
    t_chan();
    end_sim();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
